// >>> hw/asc_pkg.sv
package asc_pkg;
   // Register addresses on the internal register port
   localparam logic [3:0] ADDR_STATUS = 4'h0;
   localparam logic [3:0] ADDR_CONV_CFG = 4'h1;
   localparam logic [3:0] ADDR_GPIO_CTRL = 4'h2;
   localparam logic [3:0] ADDR_CAL_CTRL = 4'h3;

   // Status field positions
   localparam int STAT_CAL_OVER_BIT = 7;
   localparam int STAT_RATE_LSB = 4;
   localparam int STAT_OVER_BIT = 3;
   localparam int STAT_UNDER_BIT = 2;
   localparam int STAT_BUSY_BIT = 1;
   localparam int STAT_READY_BIT = 0;

   // Reset values
   localparam logic [7:0] CONV_CFG_RESET = 8'h02;
   localparam logic [7:0] GPIO_CTRL_RESET = 8'h0F;
   localparam logic [7:0] CAL_CTRL_RESET = 8'h1E;

   // Continuous mode results dropped for filter latency
   localparam logic [1:0] DISCARD_COUNT = 2'h3;

   // Result limits; raw full scale is plus or minus 2^19
   localparam logic signed [47:0] BIP_MAX = 48'sh00000007FFFF;
   localparam logic signed [47:0] BIP_MIN = -48'sh000000080000;
   localparam logic signed [47:0] UNI_MAX = 48'sh0000000FFFFF;
   localparam logic signed [47:0] UNI_MIN = 48'sh000000000000;
   localparam int GAIN_FRAC_BITS = 23;

   // Conversion configuration, bit 7 down to bit 0
   typedef struct packed {
      logic mainsSelect;
      logic unipolar;
      logic clockSourceSelect;
      logic referenceBufferEnable;
      logic inputBufferEnable;
      logic offsetFormat;
      logic singleShot;
      logic unused0;
   } asc_conv_cfg_t;

   // Calibration control, bit 7 down to bit 0
   typedef struct packed {
      logic [2:0] digitalGain;
      logic systemGainBypass;
      logic systemOffsetBypass;
      logic selfGainBypass;
      logic selfOffsetBypass;
      logic reserved0;
   } asc_cal_ctrl_t;

   // Calibration coefficients, offsets two's complement, gains Q1.23
   typedef struct packed {
      logic [23:0] selfOffset;
      logic [23:0] selfGain;
      logic [23:0] systemOffset;
      logic [23:0] systemGain;
   } asc_coef_t;

   // One register access from the serial frame logic
   typedef struct packed {
      logic wrEn;
      logic rdEn;
      logic [3:0] addr;
      logic [7:0] wrData;
   } asc_reg_req_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONVERT,
      ST_CALIBRATE
   } asc_state_t;
endpackage

// >>> hw/asc_correct.sv
module asc_correct (
   input wire logic [23:0] rawResult,
   input wire asc_pkg::asc_coef_t coef,
   input wire asc_pkg::asc_cal_ctrl_t calCtrl,
   input wire asc_pkg::asc_conv_cfg_t convCfg,
   output logic [19:0] code,
   output logic overRange,
   output logic underRange
);
   import asc_pkg::*;

   // Scale by an unsigned Q1.23 coefficient
   function automatic logic signed [47:0] mulQ(input logic signed [47:0] x,
                                               input logic [23:0] g);
      logic signed [71:0] p;
      p = 72'(x) * 72'($signed({1'b0, g}));
      return p[GAIN_FRAC_BITS +: 48];
   endfunction

   function automatic logic signed [47:0] sext(input logic [23:0] v);
      return {{24{v[23]}}, v};
   endfunction

   logic signed [47:0] s1, s2, s3, s4, s5, s6, lo, hi, clipped;

   // Correction chain: self offset, self gain, system offset, system gain
   always_comb begin
      s1 = calCtrl.selfOffsetBypass ? sext(rawResult) : sext(rawResult) - sext(coef.selfOffset);
      s2 = calCtrl.selfGainBypass ? s1 : mulQ(s1, coef.selfGain);
      s3 = calCtrl.systemOffsetBypass ? s2 : s2 - sext(coef.systemOffset);
      s4 = calCtrl.systemGainBypass ? s3 : mulQ(s3, coef.systemGain);
      s5 = convCfg.unipolar ? (s4 <<< 1) : s4;
      s6 = s5 <<< calCtrl.digitalGain;
   end

   // Limit to the range of the selected input mode
   always_comb begin
      lo = convCfg.unipolar ? UNI_MIN : BIP_MIN;
      hi = convCfg.unipolar ? UNI_MAX : BIP_MAX;
      overRange = s6 > hi;
      underRange = s6 < lo;
      clipped = overRange ? hi : (underRange ? lo : s6);
      // Bipolar offset binary flips the sign bit
      code = clipped[19:0];
      if (!convCfg.unipolar && convCfg.offsetFormat) begin
         code[19] = ~clipped[19];
      end
   end
endmodule

// >>> hw/asc_regs.sv
// Overview of operation
// - Gain calibration out of range sets flag
// - Rate field tracks held result or calibration
// - Above maximum clips and sets over flag
// - Below minimum clips and sets under flag
// - Busy flag high while modulator runs
// - New result sets ready flag
// - Idle read clears ready at next start
// - Read during conversion clears ready immediately
// - Mains bit picks 50 or 60 Hz
// - Polarity bit, one unipolar, reset bipolar
// - Clock bit one selects external clock
// - Buffer bits enable or bypass buffers
// - Format bit picks bipolar output coding
// - Single shot converts once then sleeps
// - Continuous mode drops first three results
// - Ready pin rises at conversion end
// - Direction bits make pins outputs
// - Input pins read their live level
// - Digital gain scales the calibrated result
// - System bypass bits drop system coefficients
// - Self bypass bits drop self coefficients
// - System offset between self and system gain
module asc_regs (
   input wire logic core_clk,
   input wire logic nrst,
   input wire asc_pkg::asc_reg_req_t regReq,
   output logic [7:0] regRdData,
   input wire logic dataRdDone,
   input wire logic convStart,
   input wire logic convStop,
   input wire logic calStart,
   input wire logic calDone,
   input wire logic calGainOver,
   input wire logic [2:0] rateCode,
   input wire logic rawValid,
   input wire logic [23:0] rawResult,
   input wire asc_pkg::asc_coef_t coef,
   output logic [19:0] resultData,
   output logic rdyPin,
   output logic modRun,
   output logic sleep,
   output asc_pkg::asc_conv_cfg_t convCfg,
   output asc_pkg::asc_cal_ctrl_t calCtrl,
   input wire logic [3:0] gpioIn,
   output logic [3:0] gpioOut,
   output logic [3:0] gpioOe
);
   import asc_pkg::*;

   asc_state_t state_q;
   asc_conv_cfg_t convCfg_q;
   asc_cal_ctrl_t calCtrl_q;
   logic [3:0] pinDir_q;
   logic [3:0] pinValue_q;
   logic [3:0] gpioMeta_q;
   logic [3:0] gpioSync_q;
   logic calOver_q;
   logic [2:0] runRate_q;
   logic [2:0] rate_q;
   logic over_q;
   logic under_q;
   logic ready_q;
   logic readSeen_q;
   logic [1:0] discard_q;
   logic publish_q;
   logic [19:0] result_q;
   logic rdyPin_q;
   logic sleep_q;
   logic run_q;
   logic [7:0] rdData_q;
   logic [19:0] corrCode;
   logic corrOver;
   logic corrUnder;
   logic busy;
   logic startConv;
   logic startCal;
   logic accept;

   // Address match for a register write
   function automatic logic wrHit(input asc_reg_req_t r, input logic [3:0] a);
      return r.wrEn && (r.addr == a);
   endfunction

   // Result correction, clipping and output coding
   asc_correct uCorrect (
      .rawResult(rawResult),
      .coef(coef),
      .calCtrl(calCtrl_q),
      .convCfg(convCfg_q),
      .code(corrCode),
      .overRange(corrOver),
      .underRange(corrUnder)
   );

   // Sequencer handshakes
   assign busy = (state_q != ST_IDLE);
   assign startConv = convStart && (state_q == ST_IDLE);
   assign startCal = calStart && (state_q == ST_IDLE);
   assign accept = rawValid && (state_q == ST_CONVERT) && (discard_q == 2'h0);

   // Modulator sequencer
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (startConv) begin
                  state_q <= ST_CONVERT;
               end else if (startCal) begin
                  state_q <= ST_CALIBRATE;
               end
            end
            ST_CONVERT: begin
               // Single shot stops after its one result
               if (accept && convCfg_q.singleShot) begin
                  state_q <= ST_IDLE;
               end else if (convStop) begin
                  state_q <= ST_IDLE;
               end
            end
            ST_CALIBRATE: begin
               if (calDone) begin
                  state_q <= ST_IDLE;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Registered busy output, high from an accepted start until the sequencer idles
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         run_q <= 1'b0;
      end else if (startConv || startCal) begin
         run_q <= 1'b1;
      end else if ((state_q == ST_CONVERT) && ((accept && convCfg_q.singleShot) || convStop)) begin
         run_q <= 1'b0;
      end else if ((state_q == ST_CALIBRATE) && calDone) begin
         run_q <= 1'b0;
      end
   end

   // Latency discard count for continuous conversion
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         discard_q <= 2'h0;
      end else if (startConv) begin
         discard_q <= convCfg_q.singleShot ? 2'h0 : DISCARD_COUNT;
      end else if (rawValid && (state_q == ST_CONVERT) && (discard_q != 2'h0)) begin
         discard_q <= discard_q - 2'h1;
      end
   end

   // Rate in use by the running operation
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         runRate_q <= 3'h0;
      end else if (startConv || startCal) begin
         runRate_q <= rateCode;
      end
   end

   // Result register and range flags load with each accepted sample
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         result_q <= 20'h00000;
         over_q <= 1'b0;
         under_q <= 1'b0;
      end else if (accept) begin
         result_q <= corrCode;
         over_q <= corrOver;
         under_q <= corrUnder;
      end
   end

   // Rate field follows the held result or last calibration
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rate_q <= 3'h0;
      end else if (accept || ((state_q == ST_CALIBRATE) && calDone)) begin
         rate_q <= runRate_q;
      end
   end

   // Calibration gain overrange flag
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         calOver_q <= 1'b0;
      end else if ((state_q == ST_CALIBRATE) && calDone) begin
         calOver_q <= calGainOver;
      end
   end

   // Publish one cycle after the data register has settled
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         publish_q <= 1'b0;
      end else begin
         publish_q <= accept;
      end
   end

   // Ready pin drops while data loads, then rises to mark the end
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdyPin_q <= 1'b0;
      end else if (accept || startConv) begin
         rdyPin_q <= 1'b0;
      end else if (publish_q) begin
         rdyPin_q <= 1'b1;
      end
   end

   // Remember a data read taken while the modulator was idle
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         readSeen_q <= 1'b0;
      end else if (publish_q || startConv || startCal) begin
         readSeen_q <= 1'b0;
      end else if (dataRdDone && !busy && ready_q) begin
         readSeen_q <= 1'b1;
      end
   end

   // Ready flag; a new result wins over any clear
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         ready_q <= 1'b0;
      end else if (publish_q) begin
         ready_q <= 1'b1;
      end else if (busy && dataRdDone) begin
         ready_q <= 1'b0;
      end else if ((startConv || startCal) && readSeen_q) begin
         ready_q <= 1'b0;
      end
   end

   // Leakage-only state after a single shot result
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sleep_q <= 1'b0;
      end else if (startConv || startCal) begin
         sleep_q <= 1'b0;
      end else if (accept && convCfg_q.singleShot) begin
         sleep_q <= 1'b1;
      end
   end

   // Conversion configuration register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         convCfg_q <= asc_conv_cfg_t'(CONV_CFG_RESET);
      end else if (wrHit(regReq, ADDR_CONV_CFG)) begin
         convCfg_q <= asc_conv_cfg_t'(regReq.wrData);
      end
   end

   // Calibration control register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         calCtrl_q <= asc_cal_ctrl_t'(CAL_CTRL_RESET);
      end else if (wrHit(regReq, ADDR_CAL_CTRL)) begin
         calCtrl_q <= asc_cal_ctrl_t'({regReq.wrData[7:1], 1'b0});
      end
   end

   // Pin direction and value register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pinDir_q <= GPIO_CTRL_RESET[7:4];
         pinValue_q <= GPIO_CTRL_RESET[3:0];
      end else if (wrHit(regReq, ADDR_GPIO_CTRL)) begin
         pinDir_q <= regReq.wrData[7:4];
         pinValue_q <= regReq.wrData[3:0];
      end
   end

   // Two-stage synchroniser per general-purpose pin
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : gSync
         always_ff @(posedge core_clk or negedge nrst) begin
            if (!nrst) begin
               gpioMeta_q[gi] <= 1'b0;
               gpioSync_q[gi] <= 1'b0;
            end else begin
               gpioMeta_q[gi] <= gpioIn[gi];
               gpioSync_q[gi] <= gpioMeta_q[gi];
            end
         end
      end
   endgenerate

   // Registered read data, one cycle after the request
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdData_q <= 8'h00;
      end else if (regReq.rdEn) begin
         case (regReq.addr)
            ADDR_STATUS: begin
               rdData_q <= 8'h00;
               rdData_q[STAT_CAL_OVER_BIT] <= calOver_q;
               rdData_q[STAT_RATE_LSB +: 3] <= rate_q;
               rdData_q[STAT_OVER_BIT] <= over_q;
               rdData_q[STAT_UNDER_BIT] <= under_q;
               rdData_q[STAT_BUSY_BIT] <= busy;
               rdData_q[STAT_READY_BIT] <= ready_q;
            end
            ADDR_CONV_CFG: begin
               rdData_q <= convCfg_q;
            end
            ADDR_GPIO_CTRL: begin
               // Input pins report their live level
               rdData_q <= {pinDir_q, (pinDir_q & pinValue_q) | (~pinDir_q & gpioSync_q)};
            end
            ADDR_CAL_CTRL: begin
               rdData_q <= calCtrl_q;
            end
            default: begin
               rdData_q <= 8'h00;
            end
         endcase
      end
   end

   // Outputs, each straight from a register
   assign regRdData = rdData_q;
   assign resultData = result_q;
   assign rdyPin = rdyPin_q;
   assign modRun = run_q;
   assign sleep = sleep_q;
   assign convCfg = convCfg_q;
   assign calCtrl = calCtrl_q;
   assign gpioOut = pinValue_q;
   assign gpioOe = pinDir_q;
endmodule

// >>> verif/asc_regs_props.sv
module asc_regs_props
   import asc_pkg::*;
(
   input wire logic core_clk,
   input wire logic nrst,
   input wire asc_pkg::asc_reg_req_t regReq,
   input wire logic [7:0] regRdData,
   input wire logic convStart,
   input wire logic rawValid,
   input wire logic rdyPin,
   input wire logic modRun,
   input wire logic sleep,
   input wire asc_pkg::asc_conv_cfg_t convCfg,
   input wire asc_pkg::asc_cal_ctrl_t calCtrl,
   input wire logic [3:0] gpioOut,
   input wire logic [3:0] gpioOe
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // Result publish: pin low in the cycle after the accept, then high
   sequence s_pub;
      !rdyPin ##1 rdyPin;
   endsequence
   sequence s_acc;
      rawValid && modRun && convCfg.singleShot;
   endsequence
   property p_start; convStart && !modRun |=> modRun; endproperty
   property p_single; s_acc |=> !modRun && sleep; endproperty
   property p_edge; s_acc |=> s_pub; endproperty
   property p_hold; rdyPin && !rawValid && !convStart |=> rdyPin; endproperty
   property p_cfg;
      regReq.wrEn && regReq.addr == ADDR_CONV_CFG |=> convCfg[7:1] == $past(regReq.wrData[7:1]);
   endproperty
   property p_cal;
      regReq.wrEn && regReq.addr == ADDR_CAL_CTRL
         |=> calCtrl == {$past(regReq.wrData[7:1]), 1'b0};
   endproperty
   property p_gpio;
      regReq.wrEn && regReq.addr == ADDR_GPIO_CTRL
         |=> gpioOe == $past(regReq.wrData[7:4]) && gpioOut == $past(regReq.wrData[3:0]);
   endproperty
   property p_busy;
      regReq.rdEn && regReq.addr == ADDR_STATUS |=> regRdData[STAT_BUSY_BIT] == $past(modRun);
   endproperty
   property p_dir;
      regReq.rdEn && regReq.addr == ADDR_GPIO_CTRL |=> regRdData[7:4] == $past(gpioOe);
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   a_single: assert property (p_single) else $error("no sleep after result");
   a_edge: assert property (p_edge) else $error("no ready edge");
   a_hold: assert property (p_hold) else $error("ready pin dropped");
   a_cfg: assert property (p_cfg) else $error("config write lost");
   a_cal: assert property (p_cal) else $error("cal write lost");
   a_gpio: assert property (p_gpio) else $error("pin drive wrong");
   a_busy: assert property (p_busy) else $error("busy bit wrong");
   a_dir: assert property (p_dir) else $error("direction read wrong");
endmodule
bind asc_regs asc_regs_props asc_regs_props_inst (.core_clk(core_clk), .nrst(nrst),
   .regReq(regReq), .regRdData(regRdData), .convStart(convStart), .rawValid(rawValid),
   .rdyPin(rdyPin), .modRun(modRun), .sleep(sleep), .convCfg(convCfg), .calCtrl(calCtrl),
   .gpioOut(gpioOut), .gpioOe(gpioOe));

// >>> verif/asc_host_model.sv
module asc_host_model (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic rdyPin,
   input wire logic autoRd,
   input wire logic slow,
   input wire logic rdReq,
   output logic dataRdDone
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rdyPrev_q;
   logic [2:0] pend_q;
   // Start a data read on each rising ready edge while autoRd is set
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rdyPrev_q <= 1'b0;
         pend_q <= 3'h0;
      end else begin
         rdyPrev_q <= rdyPin;
         pend_q <= {pend_q[1:0], autoRd && rdyPin && !rdyPrev_q};
      end
   end
   // Read ends after one or three cycles, or when asked
   assign dataRdDone = (slow ? pend_q[2] : pend_q[0]) || rdReq;
endmodule

// >>> verif/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import asc_pkg::*;
   logic core_clk = 0, nrst = 0, autoRd = 0, slow = 0, calGainOver = 0;
   logic rdyPin, modRun, sleep, dataRdDone;
   asc_reg_req_t regReq = '0;
   logic [7:0] regRdData, d, q;
   logic [5:0] pul = '0;
   logic [2:0] rateCode = 0, nr;
   logic [23:0] rawResult = 0;
   asc_coef_t coef = '0;
   logic [19:0] resultData, lastE;
   asc_conv_cfg_t convCfg;
   asc_cal_ctrl_t calCtrl;
   logic [3:0] gpioIn = 4'hA, gpioOut, gpioOe;
   logic [31:0] rng = 32'h8867;
   int err_count = 0, compares = 0, i, mOv = 0, mUn = 0, mCal = 0, mRate = 0, mRdy = 0;
   int expQ[$];
   int raws[6] = '{1234, 600000, -700000, -5000, 300000, 200000};
   logic [7:0] cfs[6] = '{8'h02, 8'h02, 8'h06, 8'h06, 8'h46, 8'hBA};
   logic [7:0] ccs[6] = '{8'h1E, 8'h1E, 8'h1E, 8'h1E, 8'h1E, 8'h5E};
   always #10 core_clk = ~core_clk;
   asc_regs asc_regs_inst (.core_clk(core_clk), .nrst(nrst), .regReq(regReq),
      .regRdData(regRdData), .dataRdDone(dataRdDone), .convStart(pul[0]), .convStop(pul[1]),
      .calStart(pul[2]), .calDone(pul[3]), .calGainOver(calGainOver), .rateCode(rateCode),
      .rawValid(pul[4]), .rawResult(rawResult), .coef(coef), .resultData(resultData),
      .rdyPin(rdyPin), .modRun(modRun), .sleep(sleep), .convCfg(convCfg), .calCtrl(calCtrl),
      .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe));
   asc_host_model asc_host_model_inst (.core_clk(core_clk), .nrst(nrst), .rdyPin(rdyPin),
      .autoRd(autoRd), .slow(slow), .rdReq(pul[5]), .dataRdDone(dataRdDone));
   // Stimulus helpers and the reference model
   function logic [31:0] rnd();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction
   function automatic logic [19:0] model(int raw, logic [7:0] cf, logic [7:0] cc);
      longint v;
      longint hi;
      longint lo;
      // Self offset, self gain, system offset, system gain, each unless bypassed
      v = raw;
      if (!cc[1]) v = v - longint'($signed(coef.selfOffset));
      if (!cc[2]) v = (v * longint'(coef.selfGain)) >>> GAIN_FRAC_BITS;
      if (!cc[3]) v = v - longint'($signed(coef.systemOffset));
      if (!cc[4]) v = (v * longint'(coef.systemGain)) >>> GAIN_FRAC_BITS;
      v = (cf[6] ? v * 2 : v) * (1 << cc[7:5]);
      hi = cf[6] ? 1048575 : 524287;
      lo = cf[6] ? 0 : -524288;
      mOv = v > hi;
      mUn = v < lo;
      v = mOv ? hi : (mUn ? lo : v);
      if (!cf[6] && cf[2]) v = v + 524288;
      return v[19:0];
   endfunction
   function logic [7:0] stat(int busy);
      return {mCal[0], mRate[2:0], mOv[0], mUn[0], busy[0], mRdy[0]};
   endfunction
   task finish_test();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task check(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk);
      regReq <= {1'b1, 1'b0, a, v};
      @(posedge core_clk);
      regReq <= '0;
   endtask
   task rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge core_clk);
      regReq <= {1'b0, 1'b1, a, 8'h00};
      @(posedge core_clk);
      regReq <= '0;
      @(posedge core_clk);
      v = regRdData;
   endtask
   task rdc(input logic [3:0] a, input logic [7:0] e, input string n);
      logic [7:0] v;
      rd(a, v);
      check(n, v, e);
   endtask
   task pulse(input logic [5:0] m);
      @(posedge core_clk);
      pul <= m;
      @(posedge core_clk);
      pul <= '0;
   endtask
   task waitFor(input int k);
      for (int j = 0; j < 60; j++) begin
         @(posedge core_clk);
         #1;
         if (k ? modRun === 1'b0 : rdyPin === 1'b1) begin
            @(posedge core_clk);
            return;
         end
      end
      check("wait done", 32'h0, 32'h1);
      finish_test();
   endtask
   // One single-shot conversion, optionally after a host data read
   task conv(input int raw, input logic [7:0] cf, input logic [7:0] cc, input logic rf);
      wr(ADDR_CONV_CFG, cf);
      wr(ADDR_CAL_CTRL, cc);
      rateCode <= 3'(rnd());
      if (rf) begin
         pulse(6'h20);
         rdc(ADDR_STATUS, stat(0), "rd idle");
         mRdy = 0;
      end
      pulse(6'h01);
      nr = rateCode;
      rateCode <= ~rateCode;
      rdc(ADDR_STATUS, stat(1), "busy");
      rawResult <= raw[23:0];
      expQ.push_back(model(raw, cf, cc));
      pulse(6'h10);
      waitFor(0);
      lastE = 20'(expQ.pop_front());
      mRate = nr;
      mRdy = 1;
      check("data", resultData, lastE);
      check("sleep", sleep, 1'b1);
      rdc(ADDR_STATUS, stat(0), "status");
   endtask
   // Main sequence
   initial begin
      coef = {rnd(), rnd(), rnd()};
      repeat (3) @(posedge core_clk);
      nrst <= 1'b1;
      rdc(ADDR_CONV_CFG, CONV_CFG_RESET, "cfg rst");
      rdc(ADDR_CAL_CTRL, CAL_CTRL_RESET, "cal rst");
      rdc(ADDR_GPIO_CTRL, {4'h0, gpioIn}, "pins");
      check("pin rst", gpioOut, GPIO_CTRL_RESET[3:0]);
      wr(ADDR_STATUS, 8'hFF);
      rdc(ADDR_STATUS, 8'h00, "stat ro");
      rdc(4'h9, 8'h00, "unmapped");
      for (i = 0; i < 4; i++) begin
         d = 8'(rnd());
         wr(ADDR_CONV_CFG, d);
         rd(ADDR_CONV_CFG, q);
         check("cfg", q & 8'hFE, d & 8'hFE);
         wr(ADDR_CAL_CTRL, d);
         rdc(ADDR_CAL_CTRL, d & 8'hFE, "cal");
         gpioIn <= 4'(rnd());
         wr(ADDR_GPIO_CTRL, d);
         rdc(ADDR_GPIO_CTRL, {d[7:4], (d[3:0] & d[7:4]) | (gpioIn & ~d[7:4])}, "gpio");
         check("drive", {gpioOe, gpioOut}, d);
      end
      $display("test registers done");
      for (i = 0; i < 6; i++) conv(raws[i], cfs[i], ccs[i], i[0]);
      // All four coefficients in use; the order of the chain shows in the result
      coef <= {24'h000100, 24'h900000, 24'hFFFF00, 24'h700000};
      conv(100000, 8'h02, 8'h00, 1'b0);
      $display("test single done");
      autoRd <= 1'b1;
      slow <= 1'b1;
      wr(ADDR_CONV_CFG, 8'h00);
      wr(ADDR_CAL_CTRL, CAL_CTRL_RESET);
      pulse(6'h01);
      nr = rateCode;
      for (i = 0; i < 3; i++) begin
         rawResult <= 24'(i * 1000);
         pulse(6'h10);
      end
      check("discard", {rdyPin, resultData}, {1'b0, lastE});
      rawResult <= 24'h0010E1;
      pulse(6'h10);
      waitFor(0);
      lastE = model(4321, 8'h00, CAL_CTRL_RESET);
      mRate = nr;
      mRdy = 0;
      check("cont data", resultData, lastE);
      repeat (6) @(posedge core_clk);
      rdc(ADDR_STATUS, stat(1), "auto rd");
      pulse(6'h02);
      waitFor(1);
      $display("test continuous done");
      autoRd <= 1'b0;
      rateCode <= 3'(rnd());
      pulse(6'h04);
      nr = rateCode;
      rdc(ADDR_STATUS, stat(1), "cal busy");
      calGainOver <= 1'b1;
      pulse(6'h08);
      mCal = 1;
      mRate = nr;
      rdc(ADDR_STATUS, stat(0), "cal end");
      $display("test calibration done");
      finish_test();
   end
endmodule
